// ===== hdl/cschd_pkg.sv
// Constants, command codes and status bit layout for the common status command handler
package cschd_pkg;

    // Command codes presented by the command parser on cmd_code_i
    localparam int CMD_W = 4;
    localparam logic [3:0] CMD_EVEN_SET = 4'h1;   // Load standard event enable mask
    localparam logic [3:0] CMD_EVEN_QRY = 4'h2;   // Read standard event enable mask
    localparam logic [3:0] CMD_EVREG_QRY = 4'h3;  // Read and clear standard event register
    localparam logic [3:0] CMD_SREN_SET = 4'h4;   // Load service request enable mask
    localparam logic [3:0] CMD_SREN_QRY = 4'h5;   // Read service request enable mask
    localparam logic [3:0] CMD_STAT_QRY = 4'h6;   // Read status byte
    localparam logic [3:0] CMD_TRIGGER = 4'h7;    // Start or restart measurement
    localparam logic [3:0] CMD_OPTION_QRY = 4'h8; // Installed option list

    // Status byte bit positions
    localparam int SB_QUEUE = 2;
    localparam int SB_QUES = 3;
    localparam int SB_MAV = 4;
    localparam int SB_ESB = 5;
    localparam int SB_MSS = 6;
    localparam int SB_OPER = 7;

    // Standard event register bit positions
    localparam int EV_OPC = 0;
    localparam int EV_DDE = 3;
    localparam int EV_EXE = 4;
    localparam int EV_CME = 5;
    localparam int EV_PON = 7;

    // Implemented bits; all others read as zero
    localparam logic [7:0] SREN_USED = 8'hBC;
    localparam logic [7:0] EVREG_USED = 8'hB9;

    // Reset values; power-on event is recorded at reset
    localparam logic [7:0] EVEN_RST = 8'h00;
    localparam logic [7:0] SREN_RST = 8'h00;
    localparam logic [7:0] EVREG_RST = 8'h80;

    // Decimal response text
    localparam int RESP_CHARS = 3;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] DEC_HUNDRED = 8'h64;
    localparam logic [7:0] DEC_TEN = 8'h0A;

    // Response holder states
    typedef enum logic {
        CSCHD_IDLE,
        CSCHD_HOLD
    } cschd_state_t;

endpackage

// ===== hdl/cschd_nr1_fmt.sv
// Binary to left-justified decimal text converter for numeric responses
`timescale 1ns/1ps
module cschd_nr1_fmt
    import cschd_pkg::*;
(
    // Value to format
    input wire logic [7:0] value_i,
    // Text, first character in the top byte, unused bytes zero
    output logic [8*RESP_CHARS-1:0] text_o,
    output logic [1:0] len_o
);

    logic [7:0] hun;
    logic [7:0] rem;
    logic [7:0] ten;
    logic [7:0] one;
    logic [7:0] hun_c;
    logic [7:0] ten_c;
    logic [7:0] one_c;

    // Digit split by constant division; small enough to stay combinational
    assign hun = value_i / DEC_HUNDRED;
    assign rem = value_i - 8'(hun * DEC_HUNDRED);
    assign ten = rem / DEC_TEN;
    assign one = rem - 8'(ten * DEC_TEN);

    // Digits as characters
    assign hun_c = ASCII_ZERO + hun;
    assign ten_c = ASCII_ZERO + ten;
    assign one_c = ASCII_ZERO + one;

    // Leading zeros suppressed, a lone zero still gives one character
    assign text_o = (hun != 8'h00) ? {hun_c, ten_c, one_c} :
                    (ten != 8'h00) ? {ten_c, one_c, 8'h00} : {one_c, 16'h0000};
    assign len_o = (hun != 8'h00) ? 2'h3 : (ten != 8'h00) ? 2'h2 : 2'h1;

endmodule

// ===== hdl/cschd_top.sv
// Common status command handler: event, enable and status byte registers with query responses
`timescale 1ns/1ps
module cschd_top
    import cschd_pkg::*;
#(
    parameter int PARAM_W = 16
)
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Decoded command from the message parser
    input wire logic cmd_valid_i,
    input wire logic [CMD_W-1:0] cmd_code_i,
    input wire logic [PARAM_W-1:0] cmd_param_i,
    output logic cmd_ready_o,
    // Bus level group execute trigger
    input wire logic get_i,
    // Response toward the output queue
    output logic resp_valid_o,
    output logic [7:0] resp_value_o,
    output logic [8*RESP_CHARS-1:0] resp_text_o,
    output logic [1:0] resp_len_o,
    input wire logic resp_ready_i,
    // Standard event sources, one-cycle pulses
    input wire logic ev_opc_i,
    input wire logic ev_dde_i,
    input wire logic ev_exe_i,
    input wire logic ev_cme_i,
    // Summary inputs from the rest of the instrument
    input wire logic oper_sum_i,
    input wire logic ques_sum_i,
    input wire logic errq_nonempty_i,
    // Measurement control
    input wire logic mode_err_alarm_i,
    input wire logic meas_running_i,
    output logic meas_start_o,
    output logic meas_restart_o,
    // Status view
    output logic [7:0] status_byte_o,
    output logic srq_o
);

    // Registers
    cschd_state_t state_reg;
    cschd_state_t state_next;
    logic [7:0] even_mask_reg;
    logic [7:0] even_mask_next;
    logic [7:0] sren_mask_reg;
    logic [7:0] sren_mask_next;
    logic [7:0] evreg_reg;
    logic [7:0] evreg_next;
    logic cmd_ready_reg;
    logic resp_valid_reg;
    logic [7:0] resp_value_reg;
    logic [7:0] resp_value_next;
    logic [8*RESP_CHARS-1:0] resp_text_reg;
    logic [8*RESP_CHARS-1:0] resp_text_next;
    logic [1:0] resp_len_reg;
    logic [1:0] resp_len_next;
    logic meas_start_reg;
    logic meas_restart_reg;
    logic [7:0] status_byte_reg;
    logic srq_reg;

    // Decode wires
    logic cmd_take;
    logic is_even_set;
    logic is_even_qry;
    logic is_evreg_qry;
    logic is_sren_set;
    logic is_sren_qry;
    logic is_stat_qry;
    logic is_trigger;
    logic is_option_qry;
    logic is_query;
    logic is_known;
    logic is_set;
    logic param_bad;
    logic set_ok;

    // Status wires
    logic [7:0] ev_set;
    logic evreg_clr;
    logic cmd_err_hit;
    logic esb;
    logic mav;
    logic [7:0] stb_sum;
    logic mss;
    logic [7:0] stb_full;
    logic trig_fire;
    logic [7:0] qry_value;
    logic [8*RESP_CHARS-1:0] fmt_text;
    logic [1:0] fmt_len;

    // A command is taken only while no response waits to be read
    // Nothing is queued here: the parser must hold its command until ready returns
    assign cmd_take = cmd_valid_i && cmd_ready_reg;

    // Command decode
    // Codes outside the table fall through to a command error below
    assign is_even_set = (cmd_code_i == CMD_EVEN_SET);
    assign is_even_qry = (cmd_code_i == CMD_EVEN_QRY);
    assign is_evreg_qry = (cmd_code_i == CMD_EVREG_QRY);
    assign is_sren_set = (cmd_code_i == CMD_SREN_SET);
    assign is_sren_qry = (cmd_code_i == CMD_SREN_QRY);
    assign is_stat_qry = (cmd_code_i == CMD_STAT_QRY);
    assign is_trigger = (cmd_code_i == CMD_TRIGGER);
    assign is_option_qry = (cmd_code_i == CMD_OPTION_QRY);

    // Command classes
    assign is_query = is_even_qry || is_evreg_qry || is_sren_qry || is_stat_qry || is_option_qry;
    assign is_set = is_even_set || is_sren_set;
    assign is_known = is_query || is_set || is_trigger;

    // A mask value above 255 is refused and counts as a command error
    // Only the low byte is a mask; the upper bits exist to catch oversized values
    assign param_bad = |cmd_param_i[PARAM_W-1:8];
    assign set_ok = cmd_take && is_set && !param_bad;

    // Event enable mask load
    assign even_mask_next = (set_ok && is_even_set) ? cmd_param_i[7:0] : even_mask_reg;

    // Service request mask load; unassigned bits forced to zero
    assign sren_mask_next = (set_ok && is_sren_set) ? (cmd_param_i[7:0] & SREN_USED) : sren_mask_reg;

    // Unknown code or out of range mask is a command error of our own
    assign cmd_err_hit = cmd_take && (!is_known || (is_set && param_bad));

    // Event sources gathered into their register positions
    always_comb begin
        ev_set = 8'h00;
        ev_set[EV_OPC] = ev_opc_i;
        ev_set[EV_DDE] = ev_dde_i;
        ev_set[EV_EXE] = ev_exe_i;
        ev_set[EV_CME] = ev_cme_i || cmd_err_hit;
    end

    // Reading the event register clears it
    assign evreg_clr = cmd_take && is_evreg_qry;

    // Per bit: a new event beats the clear of the same cycle so none is lost
    // Unimplemented bits can never set, so they always read back as zero
    for (genvar gi = 0; gi < 8; gi++) begin : g_evreg
        assign evreg_next[gi] = EVREG_USED[gi] && (ev_set[gi] || (evreg_reg[gi] && !evreg_clr));
    end

    // Event summary over enabled event bits
    assign esb = |(evreg_reg & even_mask_reg);

    // Message available while a response waits in the holder
    assign mav = (state_reg == CSCHD_HOLD);

    // Status byte without the master summary bit
    // Bits 0 and 1 stay zero; bit 6 is filled in once the summary is known
    always_comb begin
        stb_sum = 8'h00;
        stb_sum[SB_OPER] = oper_sum_i;
        stb_sum[SB_ESB] = esb;
        stb_sum[SB_MAV] = mav;
        stb_sum[SB_QUES] = ques_sum_i;
        stb_sum[SB_QUEUE] = errq_nonempty_i;
    end

    // Master summary from the enable mask overlap; mask bits 7,5,4,3,2 gate their summaries
    // Not latched: the flag falls as soon as the enabled condition clears
    assign mss = |(stb_sum & sren_mask_reg);

    // Bit 6 carries the master summary in the queried byte
    always_comb begin
        stb_full = stb_sum;
        stb_full[SB_MSS] = mss;
    end

    // Trigger command and bus trigger share one path, gated by measurement mode
    // Both sources in the same cycle still give a single pulse
    assign trig_fire = ((cmd_take && is_trigger) || get_i) && mode_err_alarm_i;

    // Query answer selection, values taken before this cycle's clear
    // The option query keeps a zero value; its text is forced empty in the holder
    always_comb begin
        case (cmd_code_i)
            CMD_EVEN_QRY: qry_value = even_mask_reg;
            CMD_EVREG_QRY: qry_value = evreg_reg;
            CMD_SREN_QRY: qry_value = sren_mask_reg;
            CMD_STAT_QRY: qry_value = stb_full;
            default: qry_value = 8'h00;
        endcase
    end

    // Decimal text of the selected value
    cschd_nr1_fmt cschd_nr1_fmt_inst (
        .value_i(qry_value),
        .text_o(fmt_text),
        .len_o(fmt_len)
    );

    // Response holder next state
    // Only one response can wait; a second query is held off by the low ready
    always_comb begin
        state_next = state_reg;
        resp_value_next = resp_value_reg;
        resp_text_next = resp_text_reg;
        resp_len_next = resp_len_reg;
        case (state_reg)
            CSCHD_IDLE: begin
                if (cmd_take && is_query) begin
                    state_next = CSCHD_HOLD;
                    resp_value_next = qry_value;
                    if (is_option_qry) begin
                        // No options installed, so the list is empty
                        resp_text_next = '0;
                        resp_len_next = 2'h0;
                    end else begin
                        resp_text_next = fmt_text;
                        resp_len_next = fmt_len;
                    end
                end
            end
            CSCHD_HOLD: begin
                // Held until the controller takes it
                if (resp_ready_i) begin
                    state_next = CSCHD_IDLE;
                end
            end
            default: begin
                state_next = CSCHD_IDLE;
            end
        endcase
    end

    // Holder state
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= CSCHD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Handshake flags registered from the next state, so both leave flops and agree with it
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_ready_reg <= 1'b0;
            resp_valid_reg <= 1'b0;
        end else begin
            cmd_ready_reg <= (state_next == CSCHD_IDLE);
            resp_valid_reg <= (state_next == CSCHD_HOLD);
        end
    end

    // Response contents
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resp_value_reg <= 8'h00;
            resp_text_reg <= '0;
            resp_len_reg <= 2'h0;
        end else begin
            resp_value_reg <= resp_value_next;
            resp_text_reg <= resp_text_next;
            resp_len_reg <= resp_len_next;
        end
    end

    // Enable masks; a write lands one cycle after the command is taken
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            even_mask_reg <= EVEN_RST;
            sren_mask_reg <= SREN_RST;
        end else begin
            even_mask_reg <= even_mask_next;
            sren_mask_reg <= sren_mask_next;
        end
    end

    // Event register; reset records the power-on event
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            evreg_reg <= EVREG_RST;
        end else begin
            evreg_reg <= evreg_next;
        end
    end

    // Measurement pulses; restart chosen when a run is already going
    // The running level is sampled with the trigger, so exactly one pulse fires
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meas_start_reg <= 1'b0;
            meas_restart_reg <= 1'b0;
        end else begin
            meas_start_reg <= trig_fire && !meas_running_i;
            meas_restart_reg <= trig_fire && meas_running_i;
        end
    end

    // Live status view, one cycle behind its sources
    // One cycle of latency is traded for pins that never glitch
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_byte_reg <= 8'h00;
            srq_reg <= 1'b0;
        end else begin
            status_byte_reg <= stb_full;
            srq_reg <= mss;
        end
    end

    // Outputs straight from flops
    // Valid has its own flop rather than a compare of the state
    assign cmd_ready_o = cmd_ready_reg;
    assign resp_valid_o = resp_valid_reg;
    assign resp_value_o = resp_value_reg;
    assign resp_text_o = resp_text_reg;
    assign resp_len_o = resp_len_reg;
    assign meas_start_o = meas_start_reg;
    assign meas_restart_o = meas_restart_reg;
    assign status_byte_o = status_byte_reg;
    assign srq_o = srq_reg;

endmodule

// ===== dv/cschd_top_checker.sv
// Concurrent checks on the ports of the common status command handler
`timescale 1ns/1ps
module cschd_top_checker
    import cschd_pkg::*;
#(
    parameter int PARAM_W = 16
)
(
    // Clock, reset and command side
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    input wire logic [CMD_W-1:0] cmd_code_i,
    input wire logic cmd_ready_o,
    input wire logic get_i,
    // Response side
    input wire logic resp_valid_o,
    input wire logic [7:0] resp_value_o,
    input wire logic [1:0] resp_len_o,
    input wire logic resp_ready_i,
    // Summaries, measurement and status
    input wire logic oper_sum_i,
    input wire logic ques_sum_i,
    input wire logic errq_nonempty_i,
    input wire logic mode_err_alarm_i,
    input wire logic meas_running_i,
    input wire logic meas_start_o,
    input wire logic meas_restart_o,
    input wire logic [7:0] status_byte_o,
    input wire logic srq_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // Command accepted this edge, whether it is a query, and whether a trigger acts
    wire take_w = cmd_valid_i && cmd_ready_o;
    wire is_qry_w = cmd_code_i inside {CMD_EVEN_QRY, CMD_EVREG_QRY, CMD_SREN_QRY, CMD_STAT_QRY, CMD_OPTION_QRY};
    wire trig_w = mode_err_alarm_i && (get_i || (take_w && cmd_code_i == CMD_TRIGGER));

    chk_query_answers: assert property (take_w && is_qry_w |=> resp_valid_o)
        else $error("query without response");
    chk_resp_stands: assert property (
        resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_value_o))
        else $error("response dropped before consumed");
    chk_busy_blocks: assert property (resp_valid_o |-> !cmd_ready_o)
        else $error("ready while response held");
    chk_opt_empty: assert property (take_w && cmd_code_i == CMD_OPTION_QRY |=> resp_len_o == 2'h0)
        else $error("option response not empty");
    chk_summary_map: assert property (
        status_byte_o[SB_OPER] == $past(oper_sum_i) && status_byte_o[SB_QUES] == $past(ques_sum_i)
        && status_byte_o[SB_QUEUE] == $past(errq_nonempty_i))
        else $error("summary bits wrong");
    chk_unused_zero: assert property (status_byte_o[1:0] == 2'h0)
        else $error("unused status bits set");
    chk_srq_mss: assert property (srq_o == status_byte_o[SB_MSS])
        else $error("service request flag differs from master summary");
    chk_trig_gate: assert property ((meas_start_o || meas_restart_o) |-> $past(mode_err_alarm_i))
        else $error("trigger acted outside error mode");
    chk_trig_kind: assert property (
        trig_w |=> meas_start_o == !$past(meas_running_i) && meas_restart_o == $past(meas_running_i))
        else $error("wrong trigger pulse");
    chk_get_start: assert property (
        get_i && mode_err_alarm_i && !meas_running_i |=> meas_start_o ##1 !meas_start_o)
        else $error("group trigger did not start");
endmodule

bind cschd_top cschd_top_checker #(.PARAM_W(PARAM_W)) cschd_top_checker_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_ready_o(cmd_ready_o), .get_i(get_i),
    .resp_valid_o(resp_valid_o), .resp_value_o(resp_value_o), .resp_len_o(resp_len_o), .resp_ready_i(resp_ready_i),
    .oper_sum_i(oper_sum_i), .ques_sum_i(ques_sum_i), .errq_nonempty_i(errq_nonempty_i),
    .mode_err_alarm_i(mode_err_alarm_i), .meas_running_i(meas_running_i), .meas_start_o(meas_start_o),
    .meas_restart_o(meas_restart_o), .status_byte_o(status_byte_o), .srq_o(srq_o));

// ===== dv/cschd_ctrl_model.sv
// Remote controller model that takes responses promptly or after a stall
`timescale 1ns/1ps
module cschd_ctrl_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Response handshake and stall select
    input wire logic resp_valid_i,
    input wire logic slow_i,
    output logic resp_ready_o
);
    logic [2:0] wait_reg;
    // Ready is a one-cycle pulse so a following response is never taken unseen
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_reg <= 3'h0;
            resp_ready_o <= 1'b0;
        end else if (resp_valid_i && !resp_ready_o) begin
            wait_reg <= wait_reg + 3'h1;
            resp_ready_o <= (wait_reg >= (slow_i ? 3'h5 : 3'h0));
        end else begin
            wait_reg <= 3'h0;
            resp_ready_o <= 1'b0;
        end
    end
endmodule

// ===== dv/common_status_command_handler_tb_top.sv
// Self-checking bench for the common status command handler
`timescale 1ns/1ps
module common_status_command_handler_tb_top
    import cschd_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cmd_valid_i = 1'b0, get_i = 1'b0, slow = 1'b0, mode = 1'b0, run = 1'b0, resp_ready;
    logic [3:0] cmd_code_i = 4'h0, ev_v = 4'h0;
    logic [15:0] cmd_param_i = 16'h0000;
    logic [2:0] sum_v = 3'h0;
    logic cmd_ready_o, resp_valid_o, meas_start_o, meas_restart_o, srq_o;
    logic [7:0] resp_value_o, status_byte_o;
    logic [23:0] resp_text_o;
    logic [1:0] resp_len_o;
    logic [7:0] vals [4] = '{8'h18, 8'hFF, 8'h01, 8'h64};
    logic [7:0] wts [4] = '{8'h01, 8'h08, 8'h10, 8'h20};
    int fail_count = 0, check_count = 0, cyc = 0;

    // 125 MHz clock
    always #4 mclk_i = ~mclk_i;

    cschd_top cschd_top_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
        .cmd_param_i(cmd_param_i), .cmd_ready_o(cmd_ready_o), .get_i(get_i), .resp_valid_o(resp_valid_o),
        .resp_value_o(resp_value_o), .resp_text_o(resp_text_o), .resp_len_o(resp_len_o), .resp_ready_i(resp_ready),
        .ev_opc_i(ev_v[0]), .ev_dde_i(ev_v[1]), .ev_exe_i(ev_v[2]), .ev_cme_i(ev_v[3]), .oper_sum_i(sum_v[2]),
        .ques_sum_i(sum_v[1]), .errq_nonempty_i(sum_v[0]), .mode_err_alarm_i(mode), .meas_running_i(run),
        .meas_start_o(meas_start_o), .meas_restart_o(meas_restart_o), .status_byte_o(status_byte_o), .srq_o(srq_o));
    cschd_ctrl_model cschd_ctrl_model_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .resp_valid_i(resp_valid_o),
        .slow_i(slow), .resp_ready_o(resp_ready));

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [25:0] seen, input logic [25:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // Expected decimal text and length, leading zeros dropped
    function automatic logic [25:0] dec(input logic [7:0] v);
        logic [7:0] h, t, o;
        h = ASCII_ZERO + v / 8'h64;
        t = ASCII_ZERO + (v / 8'h0A) % 8'h0A;
        o = ASCII_ZERO + v % 8'h0A;
        if (v >= 8'h64) return {h, t, o, 2'h3};
        if (v >= 8'h0A) return {t, o, 8'h00, 2'h2};
        return {o, 16'h0000, 2'h1};
    endfunction

    // Present a command and hold it until the edge that takes it
    task automatic cmd(input logic [3:0] c, input logic [15:0] p);
        int n;
        n = 0;
        cmd_valid_i <= 1'b1;
        cmd_code_i <= c;
        cmd_param_i <= p;
        do begin
            @(posedge mclk_i);
            n++;
        end while (cmd_ready_o !== 1'b1 && n < 50);
        cmd_valid_i <= 1'b0;
    endtask

    task automatic set(input logic [3:0] c, input logic [15:0] p);
        cmd(c, p);
        @(posedge mclk_i);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (cmd_ready_o !== 1'b1 && n < 50);
    endtask

    // Query, then compare value, text and length of the held response
    task automatic qry(input logic [3:0] c, input logic [7:0] v, input bit empty);
        cmd(c, 16'h0000);
        @(posedge mclk_i);
        chk("resp_valid", resp_valid_o, 26'h1);
        chk("resp_value", resp_value_o, v);
        chk("resp_text", {resp_text_o, resp_len_o}, empty ? 26'h0 : dec(v));
        wait_ready();
    endtask

    task automatic pulse(input int i);
        ev_v[i] <= 1'b1;
        @(posedge mclk_i);
        ev_v[i] <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Cycle ceiling against a hung handshake
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        repeat (5) @(posedge mclk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        // Reset contents: masks clear, power-on event recorded then cleared by its query
        qry(CMD_EVEN_QRY, 8'h00, 0);
        qry(CMD_SREN_QRY, 8'h00, 0);
        qry(CMD_EVREG_QRY, 8'h80, 0);
        qry(CMD_EVREG_QRY, 8'h00, 0);
        // Mask writes across the range, unassigned enable bits drop out
        foreach (vals[i]) begin
            set(CMD_EVEN_SET, {8'h00, vals[i]});
            qry(CMD_EVEN_QRY, vals[i], 0);
            set(CMD_SREN_SET, {8'h00, vals[i]});
            qry(CMD_SREN_QRY, vals[i] & 8'hBC, 0);
        end
        // Out of range value and unknown code are command errors only
        set(CMD_SREN_SET, 16'h0100);
        qry(CMD_SREN_QRY, 8'h24, 0);
        qry(CMD_EVREG_QRY, 8'h20, 0);
        set(4'hF, 16'h0000);
        qry(CMD_EVREG_QRY, 8'h20, 0);
        foreach (wts[i]) begin
            pulse(i);
            qry(CMD_EVREG_QRY, wts[i], 0);
        end
        // Status byte summaries, event summary and master summary
        set(CMD_SREN_SET, 16'h0000);
        set(CMD_EVEN_SET, 16'h0020);
        sum_v <= 3'h7;
        repeat (2) @(posedge mclk_i);
        chk("status", status_byte_o, 8'h8C);
        pulse(3);
        // Event lands on the first edge, the status byte shows it one edge later
        @(posedge mclk_i);
        chk("status", status_byte_o, 8'hAC);
        set(CMD_SREN_SET, 16'h0020);
        @(posedge mclk_i);
        chk("status", {srq_o, status_byte_o}, 9'h1EC);
        qry(CMD_STAT_QRY, 8'hEC, 0);
        set(CMD_EVEN_SET, 16'h0000);
        set(CMD_SREN_SET, 16'h0004);
        sum_v <= 3'h1;
        repeat (2) @(posedge mclk_i);
        chk("status", {srq_o, status_byte_o}, 9'h144);
        // Held response with a stalling controller raises message available
        sum_v <= 3'h0;
        set(CMD_SREN_SET, 16'h0010);
        slow <= 1'b1;
        cmd(CMD_SREN_QRY, 16'h0000);
        repeat (3) @(posedge mclk_i);
        chk("status", {srq_o, status_byte_o, resp_valid_o}, 10'h2A1);
        wait_ready();
        slow <= 1'b0;
        // Trigger by command and by bus trigger over every mode and run state
        for (int i = 0; i < 8; i++) begin
            mode <= i[1];
            run <= i[0];
            @(posedge mclk_i);
            if (i[2]) begin
                cmd(CMD_TRIGGER, 16'h0000);
            end else begin
                get_i <= 1'b1;
                @(posedge mclk_i);
                get_i <= 1'b0;
            end
            @(posedge mclk_i);
            chk("trigger", {meas_start_o, meas_restart_o}, {i[1] & ~i[0], i[1] & i[0]});
        end
        qry(CMD_OPTION_QRY, 8'h00, 1);
        finish_test();
    end
endmodule
